// *** logic/sbf_pkg.sv ***
package sbf_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SCK_HALF_NS = 100;
  localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SCK_DIV_LAST = 3'(SCK_HALF_CYC - 1);
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_CTRL_A = 3'h0;
  localparam logic [2:0] IDX_CTRL_B = 3'h1;
  localparam logic [2:0] IDX_INT_MASK = 3'h2;
  localparam logic [2:0] IDX_FLAGS = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRLA_EN_BIT = 0;
  localparam int unsigned CTRLA_MASTER_BIT = 5;
  localparam int unsigned CTRLB_BUF_BIT = 7;
  localparam int unsigned CTRLB_SSD_BIT = 2;
  localparam int unsigned FLAG_RXC_BIT = 7;
  localparam int unsigned FLAG_TXC_BIT = 6;
  localparam int unsigned FLAG_DRE_BIT = 5;
  localparam int unsigned FLAG_SS_TRIGGER_FLAG_BIT = 4;
  localparam int unsigned FLAG_OVF_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SBF_IDLE = 2'b01,
    SBF_SHIFT = 2'b10
  } sbf_phase_e;

  typedef struct packed {
    logic sck;
    logic ss_b;
    logic sdi;
  } sbf_pin_in_s;

  typedef struct packed {
    logic sck;
    logic sck_oe_b;
    logic sdo;
    logic sdo_oe_b;
  } sbf_pin_out_s;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } sbf_sync_s;

  typedef struct packed {
    sbf_phase_e phase;
    logic en;
    logic master;
    logic two_stage_rx_select;
    logic master_ss_ignore;
    logic [7:0] intctrl;
    logic txc;
    logic ss_trigger_flag;
    logic ovf;
    logic ovf_pend;
    logic xfer_if;
    logic [7:0] tx_hold;
    logic tx_full;
    logic [7:0] shreg;
    logic samp;
    logic [3:0] cnt;
    logic [2:0] div;
    logic sck_prev;
    logic [7:0] rx1;
    logic rx1_v;
    logic [7:0] rx2;
    logic rx2_v;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    sbf_pin_out_s pins;
  } sbf_state_s;

  localparam sbf_state_s SBF_STATE_RST = '{
    phase: SBF_IDLE,
    intctrl: REG_RESET,
    tx_hold: REG_RESET,
    shreg: REG_RESET,
    rx1: REG_RESET,
    rx2: REG_RESET,
    waitreq: 1'b1,
    pins: '{sck: 1'b0, sck_oe_b: 1'b1, sdo: 1'b0, sdo_oe_b: 1'b1},
    default: '0
  };

endpackage

// *** logic/sbf_sync2.sv ***
`timescale 1ns/1ps
module sbf_sync2
(
  input wire logic clock,
  input wire logic rst_b,
  input sbf_pkg::sbf_pin_in_s pin_in,
  output sbf_pkg::sbf_pin_in_s pin_sync
);

  sbf_pkg::sbf_sync_s sync_reg;
  sbf_pkg::sbf_sync_s sync_next;

  // idle levels: clock low, select high, data low
  always_comb
  begin
    sync_next.s1 = pin_in;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sync_reg <= '{s1: 3'h2, s2: 3'h2};
    else
      sync_reg <= sync_next;
  end

  assign pin_sync = sync_reg.s2;

endmodule

// *** logic/sbf_spi_buf.sv ***
`timescale 1ns/1ps
// Contract
// - in buffer mode a master whose select input is pulled low drops to slave and raises the select trigger flag.
// - the select trigger flag is never raised while the master select ignore bit is one.
// - writing a one to the select trigger flag position clears it.
// - with buffer mode off the select trigger and receive overrun flags read zero.
// - in buffer mode a byte finishing while both receive stages are full and a transmit byte is pending sets the overrun flag.
// - with no transmit byte pending the overrun flag is held back until the next transfer starts.
// - the overrun flag stays set until software reads the data register or switches buffer mode off.
// - in master mode a data register write starts a transfer and the byte is shifted out on the serial output.
// - in buffer mode a data read returns stage two and stage one moves into stage two.
// - buffer mode gives two receive stages, one transmit stage and separate complete flags.
// - with the master select ignore bit set a low select input leaves master mode alone.
// - in buffer mode a data register write clears the holding empty flag.
module sbf_spi_buf
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input sbf_pkg::sbf_pin_in_s pin_in,
  output sbf_pkg::sbf_pin_out_s pin_out
);

  sbf_pkg::sbf_state_s q;
  sbf_pkg::sbf_state_s d;
  sbf_pkg::sbf_pin_in_s pin_s;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  sbf_sync2 u_sync
  (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in(pin_in),
    .pin_sync(pin_s)
  );

  // ----------------------------------------------------------------
  // decode and event terms
  // ----------------------------------------------------------------
  logic acc;
  logic wr_acc;
  logic [2:0] idx;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_flags;
  logic wr_data;
  logic rd_data;
  logic div_tick;
  logic rise;
  logic fall;
  logic byte_done;
  logic ss_trig;
  logic [7:0] rx_byte;

  // one wait cycle per access; a request is acted on once only
  assign acc = (avs_read || avs_write) && q.waitreq;
  assign wr_acc = acc && avs_write && avs_byteenable[0];
  assign idx = avs_address[4:2];
  assign wr_ctrl_a = wr_acc && idx == sbf_pkg::IDX_CTRL_A;
  assign wr_ctrl_b = wr_acc && idx == sbf_pkg::IDX_CTRL_B;
  assign wr_flags = wr_acc && idx == sbf_pkg::IDX_FLAGS;
  assign wr_data = wr_acc && idx == sbf_pkg::IDX_DATA;
  assign rd_data = acc && avs_read && idx == sbf_pkg::IDX_DATA;
  assign div_tick = q.div == sbf_pkg::SCK_DIV_LAST;
  assign rise = q.master ? (div_tick && !q.pins.sck) : (pin_s.sck && !q.sck_prev);
  assign fall = q.master ? (div_tick && q.pins.sck) : (!pin_s.sck && q.sck_prev);
  assign byte_done = q.phase == sbf_pkg::SBF_SHIFT && fall && q.cnt == sbf_pkg::BYTE_BITS;
  assign ss_trig = q.en && q.master && !q.master_ss_ignore && !pin_s.ss_b;
  assign rx_byte = {q.shreg[6:0], q.samp};

  function automatic logic [7:0] flag_vec(input sbf_pkg::sbf_state_s s);
    logic [7:0] v;
    v = 8'h00;
    if (s.two_stage_rx_select)
    begin
      v[sbf_pkg::FLAG_RXC_BIT] = s.rx2_v;
      v[sbf_pkg::FLAG_TXC_BIT] = s.txc;
      v[sbf_pkg::FLAG_DRE_BIT] = !s.tx_full;
      v[sbf_pkg::FLAG_SS_TRIGGER_FLAG_BIT] = s.ss_trigger_flag;
      v[sbf_pkg::FLAG_OVF_BIT] = s.ovf;
    end
    else
      v[sbf_pkg::FLAG_RXC_BIT] = s.xfer_if;
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.sck_prev = pin_s.sck;
    d.waitreq = 1'b1;
    if (acc)
    begin
      d.waitreq = 1'b0;
      d.rdata = 32'h0000_0000;
    end
    if (wr_ctrl_a)
    begin
      d.en = avs_writedata[sbf_pkg::CTRLA_EN_BIT];
      d.master = avs_writedata[sbf_pkg::CTRLA_MASTER_BIT];
    end
    if (wr_ctrl_b)
    begin
      d.two_stage_rx_select = avs_writedata[sbf_pkg::CTRLB_BUF_BIT];
      d.master_ss_ignore = avs_writedata[sbf_pkg::CTRLB_SSD_BIT];
    end
    if (wr_acc && idx == sbf_pkg::IDX_INT_MASK)
      d.intctrl = avs_writedata[7:0];
    // overrun position is not writable; only a data read or leaving buffer mode clears it
    if (wr_flags)
    begin
      if (avs_writedata[sbf_pkg::FLAG_SS_TRIGGER_FLAG_BIT])
        d.ss_trigger_flag = 1'b0;
      if (avs_writedata[sbf_pkg::FLAG_TXC_BIT])
        d.txc = 1'b0;
      if (avs_writedata[sbf_pkg::FLAG_RXC_BIT] && !q.two_stage_rx_select)
        d.xfer_if = 1'b0;
    end
    if (acc && avs_read)
    begin
      case (idx)
        sbf_pkg::IDX_CTRL_A:
          d.rdata[7:0] = {2'b00, q.master, 4'h0, q.en};
        sbf_pkg::IDX_CTRL_B:
          d.rdata[7:0] = {q.two_stage_rx_select, 4'h0, q.master_ss_ignore, 2'b00};
        sbf_pkg::IDX_INT_MASK:
          d.rdata[7:0] = q.intctrl;
        sbf_pkg::IDX_FLAGS:
          d.rdata[7:0] = flag_vec(q);
        sbf_pkg::IDX_DATA:
          d.rdata[7:0] = q.rx2;
        default:
          d.rdata = 32'h0000_0000;
      endcase
    end
    if (rd_data)
    begin
      if (q.two_stage_rx_select)
      begin
        d.ovf = 1'b0;
        if (q.rx1_v)
        begin
          d.rx2 = q.rx1;
          d.rx1_v = 1'b0;
        end
        else
          d.rx2_v = 1'b0;
      end
      else
        d.xfer_if = 1'b0;
    end

    // shift engine
    case (q.phase)
      sbf_pkg::SBF_IDLE:
      begin
        d.div = 3'h0;
        d.cnt = 4'h0;
        if (q.en && ((q.master && q.tx_full && !ss_trig) || (!q.master && !pin_s.ss_b)))
        begin
          d.phase = sbf_pkg::SBF_SHIFT;
          d.shreg = q.tx_full ? q.tx_hold : 8'h00;
          d.tx_full = 1'b0;
          if (q.ovf_pend)
          begin
            d.ovf = 1'b1;
            d.ovf_pend = 1'b0;
          end
        end
      end
      sbf_pkg::SBF_SHIFT:
      begin
        d.div = div_tick ? 3'h0 : q.div + 3'h1;
        if (q.master && div_tick)
          d.pins.sck = !q.pins.sck;
        if (rise)
        begin
          d.samp = pin_s.sdi;
          d.cnt = q.cnt + 4'h1;
        end
        // sample on the rising edge, shift on the falling one, so the
        // outgoing bit stays put across the partner's sampling edge
        if (fall)
          d.shreg = rx_byte;
        if (byte_done)
          d.phase = sbf_pkg::SBF_IDLE;
        if (!q.en || (q.master && ss_trig) || (!q.master && pin_s.ss_b))
        begin
          d.phase = sbf_pkg::SBF_IDLE;
          d.pins.sck = 1'b0;
        end
      end
      default:
        d.phase = sbf_pkg::SBF_IDLE;
    endcase

    // select trigger: drop to slave operation
    if (ss_trig)
    begin
      d.master = 1'b0;
      if (q.two_stage_rx_select)
        d.ss_trigger_flag = 1'b1;
    end

    if (byte_done)
    begin
      if (q.two_stage_rx_select)
      begin
        if (!d.rx2_v)
        begin
          d.rx2 = rx_byte;
          d.rx2_v = 1'b1;
        end
        else if (!d.rx1_v)
        begin
          d.rx1 = rx_byte;
          d.rx1_v = 1'b1;
        end
        else if (q.tx_full)
          d.ovf = 1'b1;
        else
          d.ovf_pend = 1'b1;
        if (!q.tx_full && !wr_data)
          d.txc = 1'b1;
      end
      else
      begin
        d.rx2 = rx_byte;
        d.xfer_if = 1'b1;
      end
    end

    // holding register written after the engine so a load never eats it
    if (wr_data)
    begin
      d.tx_hold = avs_writedata[7:0];
      d.tx_full = 1'b1;
    end

    if (!d.two_stage_rx_select)
    begin
      d.ss_trigger_flag = 1'b0;
      d.ovf = 1'b0;
      d.ovf_pend = 1'b0;
      d.txc = 1'b0;
      d.rx1_v = 1'b0;
      d.rx2_v = 1'b0;
    end
    if (!d.master || d.phase == sbf_pkg::SBF_IDLE)
      d.pins.sck = 1'b0;

    if (d.two_stage_rx_select)
      d.irq = |(flag_vec(d) & d.intctrl);
    else
      d.irq = d.intctrl[0] && d.xfer_if;
    d.pins.sdo = d.shreg[7];
    d.pins.sck_oe_b = !(d.en && d.master);
    d.pins.sdo_oe_b = !(d.en && (d.master || !pin_s.ss_b));
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      q <= sbf_pkg::SBF_STATE_RST;
    else
      q <= d;
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;
  assign irq = q.irq;
  assign pin_out = q.pins;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  a_ss_to_slave: assert property (
    ss_trig && q.two_stage_rx_select && !wr_ctrl_a && !wr_ctrl_b |=> !q.master && q.ss_trigger_flag)
    else $error("select low did not force slave with trigger flag");

  a_ssd_no_flag: assert property (
    q.master_ss_ignore && !q.ss_trigger_flag && !wr_ctrl_b |=> !q.ss_trigger_flag)
    else $error("trigger flag raised while select ignored");

  a_ss_trigger_flag_w1c: assert property (
    wr_flags && avs_writedata[4] && !ss_trig && q.ss_trigger_flag |=> !q.ss_trigger_flag)
    else $error("trigger flag not cleared by one");

  a_ss_trigger_flag_keep0: assert property (
    wr_flags && !avs_writedata[4] && q.ss_trigger_flag && !wr_ctrl_b |=> q.ss_trigger_flag)
    else $error("trigger flag cleared by zero");

  a_nobuf_zero: assert property (
    !q.two_stage_rx_select |-> !q.ss_trigger_flag && !q.ovf)
    else $error("buffer flags set outside buffer mode");

  a_ovf_full: assert property (
    byte_done && q.two_stage_rx_select && q.rx1_v && q.rx2_v && !rd_data && q.tx_full && !wr_ctrl_b
    |=> q.ovf)
    else $error("overrun not flagged");

  a_ovf_defer: assert property (
    byte_done && q.two_stage_rx_select && q.rx1_v && q.rx2_v && !rd_data && !q.tx_full && !q.ovf
    && !wr_ctrl_b |=> !q.ovf && q.ovf_pend)
    else $error("overrun not deferred");

  a_ovf_hold: assert property (
    q.ovf && !rd_data && !wr_ctrl_b |=> q.ovf)
    else $error("overrun dropped without data read");

  a_data_start: assert property (
    wr_data && q.en && q.master && q.phase == sbf_pkg::SBF_IDLE && !q.tx_full && !ss_trig
    && !wr_ctrl_a |=> ##1 q.phase == sbf_pkg::SBF_SHIFT && pin_out.sdo == $past(avs_writedata[7], 2))
    else $error("data write did not start transfer");

  a_rd_stage: assert property (
    rd_data && q.two_stage_rx_select && q.rx1_v && !byte_done
    |=> avs_readdata[7:0] == $past(q.rx2) && q.rx2 == $past(q.rx1) && !q.rx1_v)
    else $error("receive stages did not advance");

  a_master_kept: assert property (
    q.master_ss_ignore && q.master && !wr_ctrl_a |=> q.master)
    else $error("master lost with select ignored");

  a_dre_clear: assert property (
    wr_data && q.two_stage_rx_select |=> q.tx_full)
    else $error("holding empty flag not cleared");

endmodule

// *** test/sbf_remote_end.sv ***
`timescale 1ns/1ps
module sbf_remote_end
(
  input wire logic sck_line,
  input wire logic sdo_line,
  input wire logic sel,
  input wire logic [7:0] first_byte,
  output logic sck_drv,
  output logic ss_b,
  output logic sdi_drv,
  output logic [7:0] got
);
  // --------
  // mode 0 far end: slave on sel, master when frame() runs
  // --------
  logic [7:0] sh;
  logic [3:0] n;
  wire act = sel | ~ss_b;

  // released line shows the inverse, so a stale bit never passes for data
  assign sdi_drv = act ? sh[7] : ~sh[7];

  initial
  begin
    sck_drv = 1'b0;
    ss_b = 1'b1;
    sh = 8'h00;
    n = 4'h0;
    got = 8'h00;
  end

  always @(posedge act)
  begin
    sh = first_byte;
    n = 4'h0;
  end

  always @(posedge sck_line)
    if (act) got = {got[6:0], sdo_line};

  // later bytes answer the inverse of the byte just heard
  always @(negedge sck_line)
  begin
    if (act)
    begin
      sh = (n == 4'h7) ? ~got : {sh[6:0], 1'b0};
      n = (n == 4'h7) ? 4'h0 : n + 4'h1;
    end
  end

  task automatic select(input logic v);
    ss_b = v;
  endtask

  // link clock stands still outside the frame
  task automatic frame();
    #7 ss_b = 1'b0;
    #200;
    repeat (8)
    begin
      #100 sck_drv = 1'b1;
      #100 sck_drv = 1'b0;
    end
    #100 ss_b = 1'b1;
  endtask
endmodule

// *** test/sbf_spi_buf_tb_top.sv ***
`timescale 1ns/1ps
module sbf_spi_buf_tb_top;
  // --------
  // signals
  // --------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  sbf_pkg::sbf_pin_in_s pin_in;
  sbf_pkg::sbf_pin_out_s pin_out;
  logic sel = 1'b0;
  logic [7:0] first_byte = 8'h3C;
  logic sck_drv;
  logic ss_b;
  logic sdi_drv;
  logic [7:0] got;
  logic [7:0] q;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  wire sck_line = pin_out.sck_oe_b ? sck_drv : pin_out.sck;
  wire sdo_line = pin_out.sdo_oe_b ? ~pin_out.sdo : pin_out.sdo;

  assign pin_in = {sck_line, ss_b, sdi_drv};

  always #12.5 clock = ~clock;

  sbf_spi_buf dut (
    .clock(clock),
    .rst_b(rst_b),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq(irq),
    .pin_in(pin_in),
    .pin_out(pin_out)
  );

  sbf_remote_end rem (
    .sck_line(sck_line),
    .sdo_line(sdo_line),
    .sel(sel),
    .first_byte(first_byte),
    .sck_drv(sck_drv),
    .ss_b(ss_b),
    .sdi_drv(sdi_drv),
    .got(got)
  );

  // --------
  // tasks
  // --------
  task automatic end_sim();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, d};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 20) error_cnt++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask

  // polls until the transfer complete flag shows
  task automatic wait_txc();
    int n;
    n = 0;
    q = 8'h00;
    while (q[6] !== 1'b1 && n < 100)
    begin
      bus(1'b0, 5'h0C, 8'h00);
      n++;
    end
    if (n == 100) error_cnt++;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // --------
  // sequence
  // --------
  initial
  begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 6; i++)
      rd(5'(4 * i), 8'hFF, 8'h00);
    wr(5'h00, 8'h21);
    rem.select(1'b0);
    repeat (8) @(posedge clock);
    rd(5'h0C, 8'h11, 8'h00);
    rem.select(1'b1);
    wr(5'h04, 8'h84);
    wr(5'h00, 8'h21);
    rem.select(1'b0);
    repeat (8) @(posedge clock);
    rd(5'h00, 8'hFF, 8'h21);
    rd(5'h0C, 8'h10, 8'h00);
    rem.select(1'b1);
    wr(5'h04, 8'h80);
    wr(5'h08, 8'h10);
    rem.select(1'b0);
    repeat (8) @(posedge clock);
    rem.select(1'b1);
    rd(5'h00, 8'hFF, 8'h01);
    rd(5'h0C, 8'h10, 8'h10);
    chk({7'h0, irq}, 8'h01);
    wr(5'h0C, 8'h00);
    rd(5'h0C, 8'h10, 8'h10);
    wr(5'h08, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wr(5'h08, 8'h10);
    wr(5'h0C, 8'h10);
    rd(5'h0C, 8'h10, 8'h00);
    chk({7'h0, irq}, 8'h00);
    // low byte lane off: the write must leave the mask alone
    avs_byteenable <= 4'hE;
    wr(5'h08, 8'hFF);
    avs_byteenable <= 4'hF;
    rd(5'h08, 8'hFF, 8'h10);
    // master transfers until both receive stages overflow
    wr(5'h00, 8'h21);
    sel <= 1'b1;
    wr(5'h10, 8'h11);
    wr(5'h10, 8'h22);
    rd(5'h0C, 8'hFF, 8'h00);
    wait_txc();
    chk(got, 8'h22);
    rd(5'h0C, 8'hFF, 8'hE0);
    wr(5'h0C, 8'h40);
    wr(5'h10, 8'h33);
    wait_txc();
    rd(5'h0C, 8'h01, 8'h00);
    wr(5'h0C, 8'h40);
    wr(5'h08, 8'h01);
    wr(5'h10, 8'h44);
    rd(5'h0C, 8'h01, 8'h01);
    wait_txc();
    wr(5'h0C, 8'h40);
    rd(5'h0C, 8'h01, 8'h01);
    chk({7'h0, irq}, 8'h01);
    rd(5'h10, 8'hFF, 8'h3C);
    rd(5'h0C, 8'h01, 8'h00);
    chk({7'h0, irq}, 8'h00);
    rd(5'h10, 8'hFF, 8'hEE);
    rd(5'h0C, 8'hFF, 8'h20);
    // slave transfer clocked by the far end
    sel <= 1'b0;
    wr(5'h00, 8'h01);
    wr(5'h10, 8'h5A);
    first_byte <= 8'h96;
    @(posedge clock);
    rem.frame();
    @(posedge clock);
    chk(got, 8'h5A);
    rd(5'h10, 8'hFF, 8'h96);
    end_sim();
  end
endmodule
